// file: hdl/sere_top.sv
// Purpose: two-wire serial EEPROM read/write engine, device side
// Assumes: SCL is the link clock; core_clk_in runs the write-cycle timer
// Notes:   array content is kept in the link domain and shown as erased
//
// What this block does
// - Up to 32 bytes in one row programmed
// - Partial rows program only received bytes
// - Acknowledge every received write data byte
// - Stop after data launches the programming cycle
// - Write address increments low five bits only
// - Row end wraps to row start
// - Busy device ignores its address byte
// - Idle device acknowledges matching address again
// - Protect input high blocks all programming
// - Protect level sampled at ending stop
// - Later protect changes leave running cycle alone
// - Protected write acknowledged, no cycle started
// - Address counter holds last access plus one
// - Current read sends byte at counter
// - Master ack advances address, wraps at top
// - Master nack ends read, back to standby
// - Array reads FFh as delivered
// - Match type nibble, straps, take direction
// - Address mismatch gives no ack, standby
// - Two word-address bytes form 13-bit location
`timescale 1ns/10ps
module sere_top #(
  parameter int WR_CYCLES = sere_pkg::WR_CYC
) (
  // Core clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       rst_in,
  // Two-wire link
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n_out,
  // Straps and protection
  input  wire logic [2:0] strap_select_in,
  input  wire logic       wp_in,
  // Status
  output logic            busy_out
);
  sere_pkg::sere_cond_t cond;

  // Core domain
  logic [2:0]                  core_s;
  logic                        stop_prev_r;
  logic                        stop_prev_nxt;
  logic                        busy_r;
  logic                        busy_nxt;
  logic [sere_pkg::TMR_W-1:0]  tmr_r;
  logic [sere_pkg::TMR_W-1:0]  tmr_nxt;
  logic                        stop_ev;

  // Link domain
  logic [4:0]                  link_s;
  logic                        rst_s;
  logic                        busy_s;
  logic [2:0]                  strap_s;
  sere_pkg::sere_state_t       st_r;
  sere_pkg::sere_state_t       st_nxt;
  sere_pkg::sere_state_t       go_r;
  sere_pkg::sere_state_t       go_nxt;
  logic [3:0]                  cnt_r;
  logic [3:0]                  cnt_nxt;
  logic [6:0]                  shift_r;
  logic [6:0]                  shift_nxt;
  logic                        ack_r;
  logic                        ack_nxt;
  logic [sere_pkg::ADDR_W-1:0] addr_r;
  logic [sere_pkg::ADDR_W-1:0] addr_nxt;
  logic [7:0]                  txd_r;
  logic [7:0]                  txd_nxt;
  logic                        start_seen_r;
  logic                        start_seen_nxt;
  logic                        stop_seen_r;
  logic                        stop_seen_nxt;
  logic                        wr_pend_r;
  logic                        wr_pend_nxt;
  logic [sere_pkg::ROW_BYTES-1:0] mask_r;
  logic [sere_pkg::ROW_BYTES-1:0] mask_nxt;
  logic                        oe_n_r = 1'b1;
  logic                        oe_n_nxt;
  logic                        wr_en;
  logic                        commit;
  logic [7:0]                  rx_byte;
  logic                        dev_match;

  logic [7:0] mem    [0:sere_pkg::ARR_BYTES-1] = '{default: sere_pkg::ERASED};
  logic [7:0] rowbuf [0:sere_pkg::ROW_BYTES-1];

  sere_cond u_cond (
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .wp_in    (wp_in),
    .cond_out (cond)
  );

  sere_sync #(.W(3)) u_core_sync (
    .clk_in (core_clk_in),
    .d_in   ({cond.stop_tgl, cond.stop_wp, wr_pend_r}),
    .q_out  (core_s)
  );

  sere_sync #(.W(5)) u_link_sync (
    .clk_in (scl_in),
    .d_in   ({busy_r, rst_in, strap_select_in}),
    .q_out  (link_s)
  );

  assign rst_s   = link_s[3];
  assign busy_s  = link_s[4];
  assign strap_s = link_s[2:0];

  // Core domain: write-cycle timer
  assign stop_ev = core_s[2] ^ stop_prev_r;

  always_comb begin
    stop_prev_nxt = core_s[2];
    busy_nxt      = busy_r;
    tmr_nxt       = tmr_r;
    if (busy_r) begin
      // Launched cycle runs to its end whatever the protect pin does
      if (tmr_r == sere_pkg::TMR_W'(1)) begin
        busy_nxt = 1'b0;
      end
      tmr_nxt = tmr_r - sere_pkg::TMR_W'(1);
    end else if (stop_ev && core_s[0] && !core_s[1]) begin
      busy_nxt = 1'b1;
      tmr_nxt  = sere_pkg::TMR_W'(WR_CYCLES);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      stop_prev_r <= 1'b0;
      busy_r      <= 1'b0;
      tmr_r       <= '0;
    end else begin
      stop_prev_r <= stop_prev_nxt;
      busy_r      <= busy_nxt;
      tmr_r       <= tmr_nxt;
    end
  end

  assign busy_out = busy_r;

  // Link domain: byte protocol on rising SCL
  assign rx_byte   = {shift_r, sda_in};
  assign dev_match = (rx_byte[7:4] == sere_pkg::DEV_TYPE_ID) &&
                     (rx_byte[3:1] == strap_s);

  always_comb begin
    st_nxt         = st_r;
    go_nxt         = go_r;
    cnt_nxt        = cnt_r;
    shift_nxt      = shift_r;
    ack_nxt        = ack_r;
    addr_nxt       = addr_r;
    txd_nxt        = txd_r;
    start_seen_nxt = start_seen_r;
    stop_seen_nxt  = stop_seen_r;
    wr_pend_nxt    = wr_pend_r;
    mask_nxt       = mask_r;
    wr_en          = 1'b0;
    commit         = 1'b0;
    if (cond.start_tgl != start_seen_r) begin
      // Commit waits for the next frame; reads are refused while busy anyway
      start_seen_nxt = cond.start_tgl;
      stop_seen_nxt  = cond.stop_tgl;
      commit         = (cond.stop_tgl != stop_seen_r) && wr_pend_r &&
                       !cond.stop_wp;
      wr_pend_nxt    = 1'b0;
      mask_nxt       = '0;
      st_nxt         = sere_pkg::ST_DEV;
      cnt_nxt        = 4'h1;
      shift_nxt      = {6'h00, sda_in};
      ack_nxt        = 1'b0;
    end else begin
      unique case (st_r)
        sere_pkg::ST_IDLE: begin
        end
        sere_pkg::ST_RDATA: begin
          if (cnt_r == sere_pkg::ACK_SLOT) begin
            cnt_nxt = 4'h0;
            if (!sda_in) begin
              txd_nxt  = mem[addr_r];
              addr_nxt = addr_r + sere_pkg::ADDR_W'(1);
            end else begin
              st_nxt = sere_pkg::ST_IDLE;
            end
          end else begin
            cnt_nxt = cnt_r + 4'h1;
          end
        end
        sere_pkg::ST_DEV, sere_pkg::ST_WA1, sere_pkg::ST_WA2, sere_pkg::ST_WDATA: begin
          if (cnt_r == sere_pkg::ACK_SLOT) begin
            st_nxt  = go_r;
            cnt_nxt = 4'h0;
            ack_nxt = 1'b0;
          end else if (cnt_r == sere_pkg::LAST_BIT) begin
            cnt_nxt = sere_pkg::ACK_SLOT;
            ack_nxt = 1'b1;
            unique case (st_r)
              sere_pkg::ST_DEV: begin
                ack_nxt = dev_match && !busy_s;
                if (!(dev_match && !busy_s)) begin
                  go_nxt = sere_pkg::ST_IDLE;
                end else if (rx_byte[0]) begin
                  go_nxt   = sere_pkg::ST_RDATA;
                  txd_nxt  = mem[addr_r];
                  addr_nxt = addr_r + sere_pkg::ADDR_W'(1);
                end else begin
                  go_nxt = sere_pkg::ST_WA1;
                end
              end
              sere_pkg::ST_WA1: begin
                addr_nxt[12:8] = rx_byte[4:0];
                go_nxt         = sere_pkg::ST_WA2;
              end
              sere_pkg::ST_WA2: begin
                addr_nxt[7:0] = rx_byte;
                go_nxt        = sere_pkg::ST_WDATA;
              end
              default: begin
                wr_en                  = 1'b1;
                mask_nxt[addr_r[4:0]]  = 1'b1;
                addr_nxt[4:0]          = addr_r[4:0] + 5'h01;
                wr_pend_nxt            = 1'b1;
                go_nxt                 = sere_pkg::ST_WDATA;
              end
            endcase
          end else begin
            shift_nxt = rx_byte[6:0];
            cnt_nxt   = cnt_r + 4'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge scl_in) begin
    if (rst_s) begin
      st_r         <= sere_pkg::ST_IDLE;
      go_r         <= sere_pkg::ST_IDLE;
      cnt_r        <= 4'h0;
      shift_r      <= 7'h00;
      ack_r        <= 1'b0;
      addr_r       <= '0;
      txd_r        <= 8'h00;
      start_seen_r <= cond.start_tgl;
      stop_seen_r  <= cond.stop_tgl;
      wr_pend_r    <= 1'b0;
      mask_r       <= '0;
    end else begin
      st_r         <= st_nxt;
      go_r         <= go_nxt;
      cnt_r        <= cnt_nxt;
      shift_r      <= shift_nxt;
      ack_r        <= ack_nxt;
      addr_r       <= addr_nxt;
      txd_r        <= txd_nxt;
      start_seen_r <= start_seen_nxt;
      stop_seen_r  <= stop_seen_nxt;
      wr_pend_r    <= wr_pend_nxt;
      mask_r       <= mask_nxt;
    end
  end

  // Row buffer and array; only flagged bytes of the row are touched
  always_ff @(posedge scl_in) begin
    if (wr_en) begin
      rowbuf[addr_r[4:0]] <= rx_byte;
    end
    if (commit) begin
      for (int i = 0; i < sere_pkg::ROW_BYTES; i++) begin
        if (mask_r[i]) begin
          mem[{addr_r[12:5], i[4:0]}] <= rowbuf[i];
        end
      end
    end
  end

  // SDA drive changes on falling SCL; open drain, only zeros are driven
  always_comb begin
    oe_n_nxt = 1'b1;
    if (st_r == sere_pkg::ST_RDATA) begin
      if (cnt_r != sere_pkg::ACK_SLOT) begin
        oe_n_nxt = txd_r[~cnt_r[2:0]];
      end
    end else if (cnt_r == sere_pkg::ACK_SLOT && ack_r) begin
      oe_n_nxt = 1'b0;
    end
  end

  always_ff @(negedge scl_in) begin
    if (rst_s) begin
      oe_n_r <= 1'b1;
    end else begin
      oe_n_r <= oe_n_nxt;
    end
  end

  assign sda_out      = 1'b0;
  assign sda_oe_n_out = oe_n_r;

  dev_nack_busy_a: assert property (@(posedge scl_in) disable iff (rst_s)
    (st_r == sere_pkg::ST_DEV && cnt_r == sere_pkg::LAST_BIT && busy_s &&
     cond.start_tgl == start_seen_r) |=> !ack_r ##1 st_r == sere_pkg::ST_IDLE)
    else $error("address acknowledged while busy");

  dev_ack_idle_a: assert property (@(posedge scl_in) disable iff (rst_s)
    (st_r == sere_pkg::ST_DEV && cnt_r == sere_pkg::LAST_BIT && !busy_s && dev_match &&
     cond.start_tgl == start_seen_r) |=> ack_r && cnt_r == sere_pkg::ACK_SLOT)
    else $error("matching address not acknowledged");

  dev_mismatch_a: assert property (@(posedge scl_in) disable iff (rst_s)
    (st_r == sere_pkg::ST_DEV && cnt_r == sere_pkg::LAST_BIT && !dev_match &&
     cond.start_tgl == start_seen_r) |=> !ack_r)
    else $error("mismatched address acknowledged");

  data_ack_a: assert property (@(posedge scl_in) disable iff (rst_s)
    (st_r == sere_pkg::ST_WDATA && cnt_r == sere_pkg::LAST_BIT &&
     cond.start_tgl == start_seen_r) |=> ack_r)
    else $error("write data byte not acknowledged");

  row_wrap_a: assert property (@(posedge scl_in) disable iff (rst_s)
    (st_r == sere_pkg::ST_WDATA && cnt_r == sere_pkg::LAST_BIT &&
     cond.start_tgl == start_seen_r) |=> addr_r[12:5] == $past(addr_r[12:5]) &&
     addr_r[4:0] == $past(addr_r[4:0]) + 5'h01)
    else $error("write address left its row");

  read_adv_a: assert property (@(posedge scl_in) disable iff (rst_s)
    (st_r == sere_pkg::ST_RDATA && cnt_r == sere_pkg::ACK_SLOT && !sda_in &&
     cond.start_tgl == start_seen_r) |=> addr_r == $past(addr_r) + 13'h0001)
    else $error("read address did not advance");

  read_nack_a: assert property (@(posedge scl_in) disable iff (rst_s)
    (st_r == sere_pkg::ST_RDATA && cnt_r == sere_pkg::ACK_SLOT && sda_in &&
     cond.start_tgl == start_seen_r) |=> st_r == sere_pkg::ST_IDLE ##1 oe_n_r)
    else $error("read not ended by master nack");

  cycle_launch_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (!busy_r && stop_ev && core_s[0] && !core_s[1]) |=> busy_r ##1 busy_r)
    else $error("programming cycle not launched at stop");

  protect_skip_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (!busy_r && stop_ev && core_s[1]) |=> !busy_r)
    else $error("protected write started a cycle");
endmodule // sere_top

// file: hdl/sere_pkg.sv
// Purpose: shared constants and types of the serial EEPROM engine
// Assumes: core clock of 25 MHz, 13-bit array address, 32-byte rows
// Notes:   link-side and core-side logic both use these names
package sere_pkg;
  localparam int          ADDR_W     = 13;
  localparam int          COL_W      = 5;
  localparam int          ROW_BYTES  = 32;
  localparam int          ARR_BYTES  = 8192;
  localparam logic [7:0]  ERASED     = 8'hFF;
  // Device type identifier compared against the top nibble; value arbitrary
  localparam logic [3:0]  DEV_TYPE_ID = 4'h5;
  // Bit counter: 0..7 data bits, 8 is the acknowledge slot
  localparam logic [3:0]  LAST_BIT   = 4'h7;
  localparam logic [3:0]  ACK_SLOT   = 4'h8;
  // Longest self-timed programming time and core clock period
  localparam int          TWR_NS     = 5000000;
  localparam int          CORE_NS    = 40;
  localparam int          WR_CYC     = TWR_NS / CORE_NS;
  localparam int          TMR_W      = 17;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_DEV   = 6'h02,
    ST_WA1   = 6'h04,
    ST_WA2   = 6'h08,
    ST_WDATA = 6'h10,
    ST_RDATA = 6'h20
  } sere_state_t;

  // Start/stop events and the write-protect level caught at stop
  typedef struct packed {
    logic start_tgl;
    logic stop_tgl;
    logic stop_wp;
  } sere_cond_t;
endpackage

// file: hdl/sere_sync.sv
// Purpose: two-flop level synchroniser
// Assumes: inputs are levels or toggles that stay stable for two edges
// Notes:   first stage is read by the second stage only
`timescale 1ns/10ps
module sere_sync #(
  parameter int W = 1
) (
  // Clock
  input  wire logic         clk_in,
  // Data
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] hold_r;

  always_ff @(posedge clk_in) begin
    meta_r <= d_in;
    hold_r <= meta_r;
  end

  assign q_out = hold_r;
endmodule // sere_sync

// file: hdl/sere_cond.sv
// Purpose: start and stop detection on the two-wire pins
// Assumes: SDA only changes while SCL is high to form start or stop
// Notes:   toggles stay stable for a whole frame, so readers may sync them
`timescale 1ns/10ps
module sere_cond (
  // Bus pins
  input  wire logic             scl_in,
  input  wire logic             sda_in,
  // Write protect pin
  input  wire logic             wp_in,
  // Events
  output sere_pkg::sere_cond_t  cond_out
);
  logic start_tgl_r = 1'b0;
  logic stop_tgl_r  = 1'b0;
  logic stop_wp_r   = 1'b0;

  // Falling SDA with SCL high is a start
  always_ff @(negedge sda_in) begin
    if (scl_in) begin
      start_tgl_r <= ~start_tgl_r;
    end
  end

  // Rising SDA with SCL high is a stop; protect level taken right there
  always_ff @(posedge sda_in) begin
    if (scl_in) begin
      stop_tgl_r <= ~stop_tgl_r;
      stop_wp_r  <= wp_in;
    end
  end

  assign cond_out = '{start_tgl: start_tgl_r, stop_tgl: stop_tgl_r, stop_wp: stop_wp_r};
endmodule // sere_cond

// file: hdl/placeholder_unused.sv
// Purpose: reserved slot for optional status logic of the engine
// Assumes: nothing; holds no module yet
// Notes:   left empty so the build carries no extra logic

// file: tb/sere_master.sv
// Purpose: behavioural two-wire bus master, partner of the engine
// Assumes: open-drain SDA with pull-up; SCL half period 32 ns
// Notes:   SCL rests high between frames; tasks are called by the bench
`timescale 1ns/10ps
module sere_master (
  // Two-wire lines
  output logic      scl_out,
  output logic      sda_low_out,
  input  wire logic sda_in
);
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // Idle clocks with SDA released, used around reset
  task automatic pulse(input int n);
    repeat (n) begin
      scl_out = 1'b0;
      #32;
      scl_out = 1'b1;
      #32;
    end
  endtask
  // From a low clock this forms a repeated start
  task automatic start();
    if (scl_out == 1'b0) begin
      #16;
      sda_low_out = 1'b0;
      #16;
      scl_out = 1'b1;
      #32;
    end
    sda_low_out = 1'b1;
    #32;
    scl_out = 1'b0;
  endtask
  task automatic bit_io(input logic b, output logic r);
    #16;
    sda_low_out = ~b;
    #16;
    scl_out = 1'b1;
    #16;
    r = sda_in;
    #16;
    scl_out = 1'b0;
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, ack);
  endtask
  task automatic get_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(nack, r);
  endtask
  // Bus free time well above four core cycles
  task automatic stop();
    #16;
    sda_low_out = 1'b1;
    #16;
    scl_out = 1'b1;
    #32;
    sda_low_out = 1'b0;
    #200;
  endtask
endmodule // sere_master

// file: tb/testbench.sv
// Purpose: self-checking bench of the serial EEPROM engine
// Assumes: byte-level model of array, address counter and write cycle
// Notes:   master times are multiples of 8 ns, never on a core rising edge
`timescale 1ns/10ps
module testbench;
  localparam int WR    = 50;
  localparam int LIMIT = 20000;
  logic        core_clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        wp_in = 1'b0;
  logic [2:0]  strap_select_in = 3'h0;
  logic        scl_w;
  logic        sda_low;
  logic        sda_w;
  logic        sda_out;
  logic        sda_oe_n_out;
  logic        busy_out;
  logic [31:0] seed = 32'h0000001B;
  logic [7:0]  mem_m [0:8191];
  int          mctr = 0;
  int          busy_len = 0;
  int          cycles = 0;
  int          failures = 0;
  int          n_tests = 0;
  int          a;
  logic [31:0] r;
  logic        ack;

  assign sda_w = ((sda_oe_n_out === 1'b0 && sda_out === 1'b0) || sda_low) ? 1'b0 : 1'b1;

  sere_top #(.WR_CYCLES(WR)) u_sere_top (
    .core_clk_in    (core_clk_in),
    .rst_in         (rst_in),
    .scl_in         (scl_w),
    .sda_in         (sda_w),
    .sda_out        (sda_out),
    .sda_oe_n_out   (sda_oe_n_out),
    .strap_select_in(strap_select_in),
    .wp_in          (wp_in),
    .busy_out       (busy_out)
  );
  sere_master u_sere_master (
    .scl_out    (scl_w),
    .sda_low_out(sda_low),
    .sda_in     (sda_w)
  );

  always #20 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    if (busy_out === 1'b1) busy_len <= busy_len + 1;
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      failures++;
      final_report();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic dev(input logic rw, input logic exp_ack);
    logic k;
    u_sere_master.start();
    u_sere_master.put_byte({sere_pkg::DEV_TYPE_ID, strap_select_in, rw}, k);
    check(k, exp_ack);
  endtask
  // Upper three bits of the high byte are random and must be ignored
  task automatic set_addr(input int ad);
    logic        k;
    logic [31:0] x;
    dev(1'b0, 1'b0);
    x = rnd();
    u_sere_master.put_byte({x[7:5], ad[12:8]}, k);
    check(k, 1'b0);
    u_sere_master.put_byte(ad[7:0], k);
    check(k, 1'b0);
    mctr = ad;
  endtask
  // Protect level is the opposite during the bytes and after stop
  task automatic write_run(input int ad, input int n, input logic prot);
    logic        k;
    logic [31:0] x;
    logic [7:0]  pend [int];
    int          col;
    @(negedge core_clk_in) wp_in = ~prot;
    set_addr(ad);
    col = ad % 32;
    for (int i = 0; i < n; i++) begin
      x = rnd();
      u_sere_master.put_byte(x[7:0], k);
      check(k, 1'b0);
      pend[(ad & 8160) + col] = x[7:0];
      col = (col + 1) % 32;
    end
    @(negedge core_clk_in) wp_in = prot;
    busy_len = 0;
    u_sere_master.stop();
    @(negedge core_clk_in) wp_in = ~prot;
    if (!prot) foreach (pend[j]) mem_m[j] = pend[j];
    mctr = (ad & 8160) + col;
  endtask
  task automatic wait_done(input logic prot);
    logic k;
    int   polls;
    polls = 0;
    do begin
      u_sere_master.start();
      u_sere_master.put_byte({sere_pkg::DEV_TYPE_ID, strap_select_in, 1'b0}, k);
      polls++;
      u_sere_master.stop();
    end while (k !== 1'b0 && polls < 20);
    check(polls > 1, !prot);
    check(k, 1'b0);
    check(busy_len, prot ? 0 : WR);
  endtask
  task automatic read_run(input int ad, input int n);
    logic [7:0] d;
    if (ad >= 0) set_addr(ad);
    dev(1'b1, 1'b0);
    for (int i = 0; i < n; i++) begin
      u_sere_master.get_byte(i == n - 1, d);
      check(d, mem_m[mctr]);
      mctr = (mctr + 1) % 8192;
    end
    check(sda_oe_n_out, 1'b1);
    u_sere_master.stop();
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    foreach (mem_m[i]) mem_m[i] = sere_pkg::ERASED;
    r = rnd();
    strap_select_in = r[2:0];
    u_sere_master.pulse(4);
    @(negedge core_clk_in) rst_in = 1'b0;
    u_sere_master.pulse(3);
    check(busy_out, 1'b0);
    check(sda_oe_n_out, 1'b1);
    check(sda_out, 1'b0);
    read_run(-1, 2);
    r = rnd();
    a = {r[7:0], 5'h1E};
    write_run(a, 34, 1'b0);
    wait_done(1'b0);
    read_run(a - 30, 32);
    r = rnd();
    a = {r[7:0], 5'h00} + (r[15:8] % 27);
    write_run(a, 5, 1'b0);
    wait_done(1'b0);
    read_run(a & 8160, 32);
    write_run(a, 4, 1'b1);
    wait_done(1'b1);
    read_run(a, 4);
    for (int i = 0; i < 4; i++) begin
      u_sere_master.start();
      u_sere_master.put_byte({sere_pkg::DEV_TYPE_ID ^ {i == 3, 3'h0},
                              strap_select_in ^ (3'h1 << i), 1'b1}, ack);
      check(ack, 1'b1);
      u_sere_master.stop();
    end
    read_run(8190, 4);
    read_run(-1, 1);
    final_report();
  end
endmodule // testbench
